// *** core/wdrc_pkg.sv ***
package wdrc_pkg;

  // ************************************
  // Register map and command values
  // ************************************
  localparam logic [7:0] WDRC_ADDR_CAUSE = 8'hef;
  localparam logic [7:0] WDRC_ADDR_WDOG  = 8'hff;
  localparam logic [7:0] WDRC_CMD_KICK   = 8'ha5;
  localparam logic [7:0] WDRC_CMD_DIS1   = 8'hde;
  localparam logic [7:0] WDRC_CMD_DIS2   = 8'had;
  localparam logic [7:0] WDRC_CMD_LOCK   = 8'hff;

  // ************************************
  // Field positions
  // ************************************
  localparam int WDRC_BIT_CNV   = 6;
  localparam int WDRC_BIT_CMP   = 5;
  localparam int WDRC_BIT_SW    = 4;
  localparam int WDRC_BIT_POR   = 1;
  localparam int WDRC_BIT_GATE  = 7;
  localparam int WDRC_BIT_STAT  = 4;
  localparam int WDRC_IV_LSB    = 0;

  // ************************************
  // Reset values and counts
  // ************************************
  localparam logic [2:0] WDRC_IV_RST  = 3'h7;
  localparam logic [2:0] WDRC_WIN_CYC = 3'h4;
  localparam int         WDRC_CNT_W   = 21;
  localparam int         WDRC_EXP_DEF = 6;

  // ************************************
  // Carriers
  // ************************************
  typedef struct packed {
    logic rsvd;
    logic cnv;
    logic cmp;
    logic sw;
    logic wdt;
    logic mcd;
    logic por;
    logic pin;
  } wdrc_cause_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdrc_sfr_t;

  // Timeout in cycles: 2^(base+2*iv), which is 4^(3+iv) at the default base 6
  function automatic logic [WDRC_CNT_W:0] wdrc_limit(input int base,
                                                     input logic [2:0] iv);
    int sh;
    sh = base + 2 * int'(iv);
    return (WDRC_CNT_W + 1)'(1) << sh;
  endfunction

endpackage

// *** core/wdrc_wdog.sv ***
module wdrc_wdog
  import wdrc_pkg::*;
#(
  parameter int EXP_BASE = WDRC_EXP_DEF
) (
  input  wire logic                  mclk,     // System clock
  input  wire logic                  rst,      // System reset
  input  wire logic                  en,       // Watchdog running
  input  wire logic                  restart,  // Clear the count
  input  wire logic [2:0]            iv,       // Interval select
  output logic                       timeout,  // Overflow pulse
  output logic [WDRC_CNT_W-1:0]      count     // Running count
);

  // ************************************
  // Interval compare
  // ************************************
  logic [WDRC_CNT_W:0] lim;
  wire                 at_end;

  assign lim    = wdrc_limit(EXP_BASE, iv);
  assign at_end = ({1'b0, count} == lim - 1'b1);

  // Counter wraps to zero on overflow, the system reset follows anyway
  always_ff @(posedge mclk) begin
    if (rst || restart || !en) begin
      count   <= '0;
      timeout <= 1'b0;
    end else if (at_end) begin
      count   <= '0;
      timeout <= 1'b1;
    end else begin
      count   <= count + 1'b1;
      timeout <= 1'b0;
    end
  end

endmodule // wdrc_wdog

// *** core/wdrc_top.sv ***
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int EXP_BASE = WDRC_EXP_DEF  // Timeout exponent base
) (
  input  wire logic        mclk,            // System clock
  input  wire logic        rst,             // System reset
  input  wdrc_sfr_t        sfr_req,         // Register access
  input  wire logic        conv_start_input, // Routed conv start
  input  wire logic        cmp0_out,        // Comparator 0 output
  input  wire logic        pin_rst_n,       // Reset pin level
  input  wire logic        por_event,       // Supply monitor
  input  wire logic        mcd_timeout,     // Missing clock pulse
  output logic [7:0]       sfr_rdata,       // Read data
  output logic             sys_rst_req,     // Reset request
  output logic             rst_pin_out,     // Reset pin value
  output logic             rst_pin_oe,      // Reset pin drive
  output logic             wdog_active      // Watchdog running
);

  // ************************************
  // Register access decode
  // ************************************
  wire wr_cause;
  wire wr_wdog;
  wire rd_cause;
  wire rd_wdog;
  wire [7:0] wd;

  assign wd       = sfr_req.wdata;
  assign wr_cause = sfr_req.wr && (sfr_req.addr == WDRC_ADDR_CAUSE);
  assign wr_wdog  = sfr_req.wr && (sfr_req.addr == WDRC_ADDR_WDOG);
  assign rd_cause = sfr_req.rd && (sfr_req.addr == WDRC_ADDR_CAUSE);
  assign rd_wdog  = sfr_req.rd && (sfr_req.addr == WDRC_ADDR_WDOG);

  // ************************************
  // Watchdog command decode
  // ************************************
  wire cmd_kick;
  wire cmd_dis1;
  wire cmd_dis2;
  wire cmd_lock;
  wire iv_write;

  assign cmd_kick = wr_wdog && (wd == WDRC_CMD_KICK);
  assign cmd_dis1 = wr_wdog && (wd == WDRC_CMD_DIS1);
  assign cmd_dis2 = wr_wdog && (wd == WDRC_CMD_DIS2);
  assign cmd_lock = wr_wdog && (wd == WDRC_CMD_LOCK);
  // Commands all carry bit 7, so they never touch the interval
  assign iv_write = wr_wdog && !wd[WDRC_BIT_GATE];

  // ************************************
  // Watchdog control state
  // ************************************
  logic       wd_en;
  logic       wd_lock;
  logic [2:0] wd_iv;
  logic [2:0] dis_win;
  wire        dis_ok;
  wire        wd_timeout;
  logic [WDRC_CNT_W-1:0] wd_count;

  // Second disable code counts only inside the window, unlocked
  assign dis_ok = cmd_dis2 && (dis_win != 3'h0) && !wd_lock;

  // Enable, lock and interval
  always_ff @(posedge mclk) begin
    if (rst) begin
      wd_en   <= 1'b1;
      wd_lock <= 1'b0;
      wd_iv   <= WDRC_IV_RST;
    end else begin
      if (cmd_kick) begin
        wd_en <= 1'b1;
      end else if (dis_ok) begin
        wd_en <= 1'b0;
      end
      if (cmd_lock) begin
        wd_lock <= 1'b1;
      end
      if (iv_write) begin
        wd_iv <= wd[WDRC_IV_LSB +: 3];
      end
    end
  end

  // Disable window: loaded by the first code, runs down each clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      dis_win <= 3'h0;
    end else if (cmd_dis1) begin
      dis_win <= WDRC_WIN_CYC;
    end else if (dis_win != 3'h0) begin
      dis_win <= dis_win - 3'h1;
    end
  end

  // ************************************
  // Watchdog counter
  // ************************************
  wdrc_wdog #(
    .EXP_BASE (EXP_BASE)
  ) u_wdog (
    .mclk    (mclk),
    .rst     (rst),
    .en      (wd_en),
    .restart (cmd_kick),
    .iv      (wd_iv),
    .timeout (wd_timeout),
    .count   (wd_count)
  );

  // ************************************
  // Reset-cause control bits
  // ************************************
  logic cnv_en;
  logic cmp_en;
  wire  sw_force;
  wire  por_force;

  // Enables are write-only state; reads show cause flags instead
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnv_en <= 1'b0;
      cmp_en <= 1'b0;
    end else if (wr_cause) begin
      cnv_en <= wd[WDRC_BIT_CNV];
      cmp_en <= wd[WDRC_BIT_CMP];
    end
  end

  // Writing zero to the force bits does nothing
  assign sw_force  = wr_cause && wd[WDRC_BIT_SW];
  assign por_force = wr_cause && wd[WDRC_BIT_POR];

  // ************************************
  // Source merge
  // ************************************
  wire src_cnv;
  wire src_cmp;
  wire src_pin;
  wire src_por;
  wire src_any;

  assign src_cnv = cnv_en && !conv_start_input;
  assign src_cmp = cmp_en && !cmp0_out;
  assign src_pin = !pin_rst_n;
  assign src_por = por_event || por_force;
  assign src_any = src_cnv || src_cmp || src_pin || src_por ||
                   sw_force || wd_timeout || mcd_timeout;

  // ************************************
  // Pending cause
  // ************************************
  // Not cleared by rst: it must outlive the reset it names.
  // A power-on event or the first exit from rst gives it a known value from power-up.
  wdrc_cause_t pend;
  wdrc_cause_t next_pend;
  wdrc_cause_t first_src;
  logic        rst_d;
  wire         rst_exit;

  assign rst_exit = rst_d && !rst;

  // First source wins; later ones inside one reset are not recorded, except power-on
  always_comb begin
    first_src     = '0;
    first_src.pin = src_pin;
    first_src.cnv = !src_pin && src_cnv;
    first_src.cmp = !src_pin && !src_cnv && src_cmp;
    first_src.sw  = !src_pin && !src_cnv && !src_cmp && sw_force;
    first_src.wdt = !src_pin && !src_cnv && !src_cmp && !sw_force &&
                    wd_timeout;
    first_src.mcd = !src_pin && !src_cnv && !src_cmp && !sw_force &&
                    !wd_timeout && mcd_timeout;
  end

  // Power-on overrides; a new source on the exit cycle beats the clear
  always_comb begin
    next_pend = pend;
    if (src_por) begin
      next_pend     = '0;
      next_pend.por = 1'b1;
    end else if (src_any && (pend == '0 || rst_exit)) begin
      next_pend = first_src;
    end else if (rst_exit) begin
      next_pend = '0;
    end
  end

  always_ff @(posedge mclk) begin
    pend  <= next_pend;
    rst_d <= rst;
  end

  // ************************************
  // Cause register
  // ************************************
  wdrc_cause_t cause;

  // Held in reset, the register tracks the pending cause
  always_ff @(posedge mclk) begin
    if (rst) begin
      cause      <= pend;
      cause.rsvd <= 1'b0;
    end
  end

  // ************************************
  // Reset request and pin drive
  // ************************************
  // Request is a level; the system reset controller stretches it
  always_ff @(posedge mclk) begin
    if (rst) begin
      sys_rst_req <= src_pin || por_event;
      rst_pin_oe  <= por_event;
    end else begin
      sys_rst_req <= src_any;
      rst_pin_oe  <= src_por;
    end
    rst_pin_out <= 1'b0;
  end

  // ************************************
  // Read data and status
  // ************************************
  wire [7:0] wd_view;

  assign wd_view = {3'h0, wd_en, 1'b0, wd_iv};

  always_ff @(posedge mclk) begin
    if (rst) begin
      sfr_rdata   <= 8'h00;
      wdog_active <= 1'b1;
    end else begin
      wdog_active <= wd_en;
      if (rd_cause) begin
        sfr_rdata <= cause;
      end else if (rd_wdog) begin
        sfr_rdata <= wd_view;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // ************************************
  // Checks
  // ************************************
  // Second code one to four clocks after the first must stop the dog
  dis_window_a: assert property (
    @(posedge mclk) disable iff (rst)
    (cmd_dis1 && !wd_lock) ##[1:4] (cmd_dis2 && !wd_lock) |=> !wd_en)
    else $error("disable sequence did not stop watchdog");

  late_dis_a: assert property (
    @(posedge mclk) disable iff (rst)
    (dis_win == 3'h0 && cmd_dis2 && wd_en) |=> wd_en)
    else $error("late disable code was honoured");

  lock_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    (wd_lock && wd_en) |=> wd_en)
    else $error("locked watchdog was disabled");

  kick_run_a: assert property (
    @(posedge mclk) disable iff (rst)
    cmd_kick |=> (wd_en && wd_count == '0) ##1 (wd_count == 1))
    else $error("kick did not enable and restart");

  reset_def_a: assert property (
    @(posedge mclk)
    $fell(rst) |-> (wd_en && wd_iv == 3'h7 && !wd_lock))
    else $error("watchdog not at defaults after reset");

  intv_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    wr_wdog |=> (wd_iv == ($past(wd[7]) ? $past(wd_iv)
                                        : $past(wd[2:0]))))
    else $error("interval write gate wrong");

  cnv_src_a: assert property (
    @(posedge mclk) disable iff (rst)
    (cnv_en && !conv_start_input) |=> (sys_rst_req && !rst_pin_oe))
    else $error("conv start low did not request reset");

  wdt_req_a: assert property (
    @(posedge mclk) disable iff (rst)
    wd_timeout |=> sys_rst_req)
    else $error("watchdog overflow gave no reset");

  sw_force_a: assert property (
    @(posedge mclk) disable iff (rst)
    (sw_force && pend == '0 && !src_por && !src_pin && !src_cnv &&
     !src_cmp) |=> (sys_rst_req && pend.sw && !rst_pin_oe))
    else $error("soft reset not forced");

  por_pin_a: assert property (
    @(posedge mclk) disable iff (rst)
    por_force |=> (rst_pin_oe && pend.por && !pend.pin))
    else $error("forced power-on did not drive pin");

  cause_cap_a: assert property (
    @(posedge mclk)
    $fell(rst) |-> (cause[6:0] == $past(pend[6:0])))
    else $error("cause not captured from pending");

  stat_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    rd_wdog |=> (sfr_rdata[4] == $past(wd_en) &&
                 sfr_rdata[2:0] == $past(wd_iv)))
    else $error("watchdog read view wrong");

  cmp_src_a: assert property (
    @(posedge mclk) disable iff (rst)
    (cmp_en && !cmp0_out) |=> (sys_rst_req && !rst_pin_oe))
    else $error("comparator low did not request reset");

  mcd_req_a: assert property (
    @(posedge mclk) disable iff (rst)
    mcd_timeout |=> (sys_rst_req && !rst_pin_oe))
    else $error("missing clock pulse gave no reset");

endmodule // wdrc_top

// *** bench/tb_top.sv ***
module tb_top
  import wdrc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk;              // System clock
  logic       rst;               // System reset
  wdrc_sfr_t  sfr_req;           // Register access
  logic       conv_start_input;  // Routed conv start
  logic       cmp0_out;          // Comparator 0 output
  logic       pin_rst_n;         // Reset pin level
  logic       por_event;         // Supply monitor
  logic       mcd_timeout;       // Missing clock pulse
  logic [7:0] sfr_rdata;         // Read data
  logic       sys_rst_req;       // Reset request
  logic       rst_pin_out;       // Reset pin value
  logic       rst_pin_oe;        // Reset pin drive
  logic       wdog_active;       // Watchdog running
  int         num_errors;
  int         tests_run;

  // Short exponent base keeps the longest interval at 2^15 cycles
  wdrc_top #(.EXP_BASE(1)) u_wdrc_top (
    .mclk             (mclk),
    .rst              (rst),
    .sfr_req          (sfr_req),
    .conv_start_input (conv_start_input),
    .cmp0_out         (cmp0_out),
    .pin_rst_n        (pin_rst_n),
    .por_event        (por_event),
    .mcd_timeout      (mcd_timeout),
    .sfr_rdata        (sfr_rdata),
    .sys_rst_req      (sys_rst_req),
    .rst_pin_out      (rst_pin_out),
    .rst_pin_oe       (rst_pin_oe),
    .wdog_active      (wdog_active)
  );

  // Free-running clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ************************************
  // Shared helpers
  // ************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Every access starts on a fresh falling edge, so no double drive
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    sfr_req = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge mclk);
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    q = sfr_rdata;
    sfr_req = '0;
  endtask

  // Disable pair on adjacent cycles
  task automatic dis_seq();
    @(negedge mclk);
    sfr_req = '{1'b1, 1'b0, WDRC_ADDR_WDOG, WDRC_CMD_DIS1};
    @(negedge mclk);
    sfr_req = '{1'b1, 1'b0, WDRC_ADDR_WDOG, WDRC_CMD_DIS2};
    @(negedge mclk);
    sfr_req = '0;
    repeat (2) @(negedge mclk);
  endtask

  // Bounded wait for the merged request; a hang ends the run
  task automatic wait_req(output int n);
    n = 0;
    while (sys_rst_req !== 1'b1) begin
      n++;
      if (n > 200) begin
        num_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        close_out();
      end
      @(negedge mclk);
    end
  endtask

  task automatic quiet(input int c);
    logic seen;
    seen = 1'b0;
    repeat (c) begin
      @(negedge mclk);
      seen = seen | (sys_rst_req !== 1'b0);
    end
    check({7'h00, seen}, 8'h00);
  endtask

  // Sources drop early; the pending cause must outlive them
  task automatic do_reset();
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    conv_start_input = 1'b1;
    cmp0_out = 1'b1;
    pin_rst_n = 1'b1;
    por_event = 1'b0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
  endtask

  // ************************************
  // Scenarios
  // ************************************
  task automatic t_defaults();
    logic [7:0] q;
    rd(WDRC_ADDR_CAUSE, q);
    check({7'h00, q[1]}, 8'h01);
    rd(WDRC_ADDR_WDOG, q);
    check(q, 8'h17);
    rd(8'h10, q);
    check(q, 8'h00);
    wr(WDRC_ADDR_WDOG, 8'h83);
    rd(WDRC_ADDR_WDOG, q);
    check(q, 8'h17);
    wr(WDRC_ADDR_WDOG, 8'h03);
    rd(WDRC_ADDR_WDOG, q);
    check(q, 8'h13);
  endtask

  // Period difference between iv 1 and 2 is 32 - 8 cycles
  task automatic t_timeout();
    int n1;
    int n2;
    logic [7:0] q;
    wr(WDRC_ADDR_WDOG, 8'h01);
    wr(WDRC_ADDR_WDOG, WDRC_CMD_KICK);
    wait_req(n1);
    check({7'h00, rst_pin_oe}, 8'h00);
    do_reset();
    rd(WDRC_ADDR_CAUSE, q);
    check(q, 8'h08);
    wr(WDRC_ADDR_WDOG, 8'h02);
    wr(WDRC_ADDR_WDOG, WDRC_CMD_KICK);
    wait_req(n2);
    do_reset();
    check(8'(n2 - n1), 8'h18);
  endtask

  task automatic t_disable();
    int n;
    logic [7:0] q;
    dis_seq();
    check({7'h00, wdog_active}, 8'h00);
    rd(WDRC_ADDR_WDOG, q);
    check(q, 8'h07);
    wr(WDRC_ADDR_WDOG, 8'h00);
    quiet(20);
    wr(WDRC_ADDR_WDOG, WDRC_CMD_KICK);
    wait_req(n);
    do_reset();
    // Second code five cycles late must be ignored
    wr(WDRC_ADDR_WDOG, WDRC_CMD_DIS1);
    repeat (3) @(negedge mclk);
    wr(WDRC_ADDR_WDOG, WDRC_CMD_DIS2);
    repeat (2) @(negedge mclk);
    check({7'h00, wdog_active}, 8'h01);
    wr(WDRC_ADDR_WDOG, WDRC_CMD_LOCK);
    dis_seq();
    check({7'h00, wdog_active}, 8'h01);
    rd(WDRC_ADDR_WDOG, q);
    check(q, 8'h17);
    do_reset();
    dis_seq();
    check({7'h00, wdog_active}, 8'h00);
    do_reset();
  endtask

  task automatic t_sources();
    logic [7:0] q;
    logic [7:0] codes [4] = '{8'h40, 8'h20, 8'h10, 8'h02};
    int n;
    wr(WDRC_ADDR_CAUSE, 8'h00);
    conv_start_input = 1'b0;
    cmp0_out = 1'b0;
    quiet(10);
    conv_start_input = 1'b1;
    cmp0_out = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(WDRC_ADDR_CAUSE, codes[i]);
      conv_start_input = (i != 0);
      cmp0_out = (i != 1);
      wait_req(n);
      check({7'h00, rst_pin_oe}, {7'h00, i == 3});
      check({7'h00, rst_pin_out}, 8'h00);
      do_reset();
      rd(WDRC_ADDR_CAUSE, q);
      check(q & ((i == 3) ? 8'h02 : 8'hff), codes[i]);
    end
    pin_rst_n = 1'b0;
    wait_req(n);
    do_reset();
    rd(WDRC_ADDR_CAUSE, q);
    check(q, 8'h01);
    mcd_timeout = 1'b1;
    @(negedge mclk);
    mcd_timeout = 1'b0;
    wait_req(n);
    do_reset();
    rd(WDRC_ADDR_CAUSE, q);
    check(q, 8'h04);
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    num_errors = 0;
    tests_run = 0;
    rst = 1'b1;
    por_event = 1'b1;
    conv_start_input = 1'b1;
    cmp0_out = 1'b1;
    pin_rst_n = 1'b1;
    mcd_timeout = 1'b0;
    sfr_req = '0;
    do_reset();
    t_defaults();
    t_timeout();
    t_disable();
    t_sources();
    close_out();
  end

endmodule // tb_top
